// [core/acal_bank.sv]
// Input select and offset/full-scale correction for the auxiliary converter.
// Assumes raw results arrive as a one-cycle strobe with 24-bit data, and a
// register port with read data one cycle after the read strobe.
//
// Contract
// - Bits 7:4 of the input select pick the positive input: 0-9 analog inputs, 10 common, reset 0.
// - Positive codes 11-14 route temperature, analog supply, digital supply, test signal; 15 is open.
// - Bits 3:0 pick the negative input the same way on negative legs, reset 1.
// - The offset word is low byte at the lower address, high byte above, both reset zero.
// - The offset word is signed and shifted left to align with the top of the 24-bit result.
// - The aligned offset is subtracted from each raw result before scaling.
// - The full-scale word is unsigned and divided by 4000h to give the gain.
// - The offset-corrected result is multiplied by that gain to give the output.
// - The full-scale bytes reset to 00h low and 40h high.
//
// Added by the designer: the plain strobed port.
`timescale 1ns/1ps
`include "acal_params.svh"

module acal_bank
(
	input wire logic clk,
	input wire logic reset,
	input wire acal_pkg::acal_req_t req,
	output logic [7:0] rdata,
	input wire logic raw_valid,
	input wire logic [23:0] raw_data,
	output logic cal_valid,
	output logic [23:0] cal_data,
	output acal_pkg::acal_route_t pos_route,
	output acal_pkg::acal_route_t neg_route
);

	// ****************************************************************
	// Register storage
	// ****************************************************************
	logic [3:0] pos_sel_r;
	logic [3:0] neg_sel_r;
	logic [7:0] offset_low_r;
	logic [7:0] offset_high_r;
	logic [7:0] fullscale_low_r;
	logic [7:0] fullscale_high_r;
	logic [15:0] aux_offset_word;
	logic [15:0] aux_fullscale_word;
	logic [7:0] rdata_nxt;

	// Selector fields written as one byte; both legs change on the same edge,
	// so the two routes never show a half-written pair
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			pos_sel_r <= `ACAL_RST_POS_SEL;
			neg_sel_r <= `ACAL_RST_NEG_SEL;
		end
		else if (req.wr && req.addr == `ACAL_ADDR_INPUT_SELECT)
		begin
			pos_sel_r <= req.wdata[`ACAL_POS_SEL_MSB:`ACAL_POS_SEL_LSB];
			neg_sel_r <= req.wdata[`ACAL_NEG_SEL_MSB:`ACAL_NEG_SEL_LSB];
		end
	end

	// Offset bytes
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			offset_low_r <= `ACAL_RST_OFFSET_LOW;
			offset_high_r <= `ACAL_RST_OFFSET_HIGH;
		end
		else if (req.wr)
		begin
			if (req.addr == `ACAL_ADDR_OFFSET_LOW)
				offset_low_r <= req.wdata;
			if (req.addr == `ACAL_ADDR_OFFSET_HIGH)
				offset_high_r <= req.wdata;
		end
	end

	// Full-scale bytes; reset gives unity gain
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			fullscale_low_r <= `ACAL_RST_FULLSCALE_LOW;
			fullscale_high_r <= `ACAL_RST_FULLSCALE_HIGH;
		end
		else if (req.wr)
		begin
			if (req.addr == `ACAL_ADDR_FULLSCALE_LOW)
				fullscale_low_r <= req.wdata;
			if (req.addr == `ACAL_ADDR_FULLSCALE_HIGH)
				fullscale_high_r <= req.wdata;
		end
	end

	// Bytes pair into words, low byte at the lower address.
	// Each byte lands on its own, so software that rewrites a word byte by
	// byte may see one result computed with a mixed word; no shadow is kept.
	assign aux_offset_word = {offset_high_r, offset_low_r};
	assign aux_fullscale_word = {fullscale_high_r, fullscale_low_r};

	// ****************************************************************
	// Read port
	// ****************************************************************
	// Unmapped addresses read zero.
	// The result bytes have no write path, so a write there is dropped;
	// a read of them shows the last calibrated result, not a live one.
	always_comb
	begin
		rdata_nxt = 8'h00;
		unique case (req.addr)
			`ACAL_ADDR_INPUT_SELECT: rdata_nxt = {pos_sel_r, neg_sel_r};
			`ACAL_ADDR_OFFSET_LOW: rdata_nxt = offset_low_r;
			`ACAL_ADDR_OFFSET_HIGH: rdata_nxt = offset_high_r;
			`ACAL_ADDR_FULLSCALE_LOW: rdata_nxt = fullscale_low_r;
			`ACAL_ADDR_FULLSCALE_HIGH: rdata_nxt = fullscale_high_r;
			`ACAL_ADDR_RESULT_0: rdata_nxt = cal_data[7:0];
			`ACAL_ADDR_RESULT_1: rdata_nxt = cal_data[15:8];
			`ACAL_ADDR_RESULT_2: rdata_nxt = cal_data[23:16];
			default: rdata_nxt = 8'h00;
		endcase
	end

	// Read data stands only in the cycle after the strobe
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
			rdata <= 8'h00;
		else if (req.rd)
			rdata <= rdata_nxt;
		else
			rdata <= 8'h00;
	end

	// ****************************************************************
	// Input routing
	// ****************************************************************
	logic [9:0] pos_ain;
	logic [9:0] neg_ain;

	// One switch per external input and leg; each compare is a fixed code
	for (genvar g = 0; g < 10; g++)
	begin : g_ain
		assign pos_ain[g] = (pos_sel_r == 4'(g));
		assign neg_ain[g] = (neg_sel_r == 4'(g));
	end

	// Code 15 drives no switch, leaving the leg open
	always_comb
	begin
		pos_route = '0;
		neg_route = '0;
		pos_route.ain = pos_ain;
		neg_route.ain = neg_ain;
		pos_route.common = (pos_sel_r == acal_pkg::SRC_COMMON);
		pos_route.temp_mon = (pos_sel_r == acal_pkg::SRC_TEMP_MON);
		pos_route.avdd_mon = (pos_sel_r == acal_pkg::SRC_AVDD_MON);
		pos_route.dvdd_mon = (pos_sel_r == acal_pkg::SRC_DVDD_MON);
		pos_route.test_signal = (pos_sel_r == acal_pkg::SRC_TEST_SIGNAL);
		neg_route.common = (neg_sel_r == acal_pkg::SRC_COMMON);
		neg_route.temp_mon = (neg_sel_r == acal_pkg::SRC_TEMP_MON);
		neg_route.avdd_mon = (neg_sel_r == acal_pkg::SRC_AVDD_MON);
		neg_route.dvdd_mon = (neg_sel_r == acal_pkg::SRC_DVDD_MON);
		neg_route.test_signal = (neg_sel_r == acal_pkg::SRC_TEST_SIGNAL);
	end

	// ****************************************************************
	// Correction arithmetic
	// ****************************************************************
	// Widths: 25 bits hold the difference of two 24-bit values, 43 bits
	// hold that times a 16-bit word, and 29 bits the product after the
	// 14-bit drop. A narrower path would wrap before the clamp sees it.
	logic signed [24:0] corrected;
	logic signed [42:0] scaled;
	logic signed [28:0] shifted;
	logic [23:0] cal_nxt;

	// Offset aligned to the result's top 16 bits, then subtracted first
	assign corrected = 25'(signed'(raw_data)) - 25'(signed'({aux_offset_word, 8'h00}));
	// Gain is word / 4000h: multiply then drop 14 fraction bits
	assign scaled = 43'(corrected) * 43'(signed'({1'b0, aux_fullscale_word}));
	assign shifted = 29'(scaled >>> `ACAL_UNITY_SHIFT);

	// Clamp rather than wrap; 29 bits are enough since gain < 4
	always_comb
	begin
		if (shifted > 29'sh007fffff)
			cal_nxt = `ACAL_RESULT_MAX;
		else if (shifted < -29'sh00800000)
			cal_nxt = `ACAL_RESULT_MIN;
		else
			cal_nxt = shifted[23:0];
	end

	// One-cycle latency from raw strobe to calibrated strobe; the result
	// holds between strobes so a late register read still finds it
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			cal_valid <= 1'b0;
			cal_data <= 24'h000000;
		end
		else
		begin
			cal_valid <= raw_valid;
			if (raw_valid)
				cal_data <= cal_nxt;
		end
	end

	// ****************************************************************
	// Assertions
	// ****************************************************************
	// Data path timing: fixed latency, result held between strobes
	valid_latency_a: assert property (@(posedge clk) disable iff (reset)
		cal_valid == $past(raw_valid))
		else $error("calibrated strobe not one cycle after raw strobe");
	result_hold_a: assert property (@(posedge clk) disable iff (reset)
		!raw_valid |=> $stable(cal_data))
		else $error("calibrated result changed without a raw strobe");

	// Arithmetic: the first three checks use fixed operands, so their expected values
	// follow the rules alone; the saturation checks key on the datapath value shifted
	unity_passthru_a: assert property (@(posedge clk) disable iff (reset)
		raw_valid && aux_fullscale_word == 16'h4000 && aux_offset_word == 16'h0000
		|=> cal_data == $past(raw_data))
		else $error("unity gain zero offset did not pass raw result");
	offset_subtract_a: assert property (@(posedge clk) disable iff (reset)
		raw_valid && aux_fullscale_word == 16'h4000 && aux_offset_word == 16'h0100
		&& $signed(raw_data) > 24'sh100000 && $signed(raw_data) < 24'sh300000
		|=> cal_data == $past(raw_data) - 24'h010000)
		else $error("offset not subtracted in top bits");
	gain_double_a: assert property (@(posedge clk) disable iff (reset)
		raw_valid && aux_fullscale_word == 16'h8000 && aux_offset_word == 16'h0000
		&& $signed(raw_data) > -24'sh400000 && $signed(raw_data) < 24'sh400000
		|=> cal_data == {$past(raw_data[22:0]), 1'b0})
		else $error("full-scale 8000h did not double the result");
	sat_high_a: assert property (@(posedge clk) disable iff (reset)
		raw_valid && shifted > 29'sh007fffff |=> cal_data == 24'h7fffff)
		else $error("positive overflow not saturated");
	sat_low_a: assert property (@(posedge clk) disable iff (reset)
		raw_valid && shifted < -29'sh00800000 |=> cal_data == 24'h800000)
		else $error("negative overflow not saturated");

	// Routing: one switch per leg for codes 0-14, none for code 15
	pos_onehot_a: assert property (@(posedge clk) disable iff (reset)
		pos_sel_r < 4'hf |-> $onehot(pos_route))
		else $error("positive route not one-hot");
	pos_ain_a: assert property (@(posedge clk) disable iff (reset)
		pos_sel_r < 4'ha |-> pos_route.ain[pos_sel_r])
		else $error("positive external input not routed");
	pos_common_a: assert property (@(posedge clk) disable iff (reset)
		pos_sel_r == 4'ha |-> pos_route.common)
		else $error("positive common input not routed");
	pos_temp_a: assert property (@(posedge clk) disable iff (reset)
		pos_sel_r == 4'hb |-> pos_route.temp_mon)
		else $error("positive temperature monitor not routed");
	pos_avdd_a: assert property (@(posedge clk) disable iff (reset)
		pos_sel_r == 4'hc |-> pos_route.avdd_mon)
		else $error("positive analog supply monitor not routed");
	pos_dvdd_a: assert property (@(posedge clk) disable iff (reset)
		pos_sel_r == 4'hd |-> pos_route.dvdd_mon)
		else $error("positive digital supply monitor not routed");
	pos_test_a: assert property (@(posedge clk) disable iff (reset)
		pos_sel_r == 4'he |-> pos_route.test_signal)
		else $error("positive test signal not routed");
	pos_open_a: assert property (@(posedge clk) disable iff (reset)
		pos_sel_r == 4'hf |-> pos_route == '0)
		else $error("open positive code drives a switch");
	neg_onehot_a: assert property (@(posedge clk) disable iff (reset)
		neg_sel_r < 4'hf |-> $onehot(neg_route))
		else $error("negative route not one-hot");
	neg_ain_a: assert property (@(posedge clk) disable iff (reset)
		neg_sel_r < 4'ha |-> neg_route.ain[neg_sel_r])
		else $error("negative external input not routed");
	neg_common_a: assert property (@(posedge clk) disable iff (reset)
		neg_sel_r == 4'ha |-> neg_route.common)
		else $error("negative common input not routed");
	neg_temp_a: assert property (@(posedge clk) disable iff (reset)
		neg_sel_r == 4'hb |-> neg_route.temp_mon)
		else $error("negative temperature monitor not routed");
	neg_test_a: assert property (@(posedge clk) disable iff (reset)
		neg_sel_r == 4'he |-> neg_route.test_signal && $onehot(neg_route))
		else $error("negative test signal not routed");
	neg_open_a: assert property (@(posedge clk) disable iff (reset)
		neg_sel_r == 4'hf |-> neg_route == '0)
		else $error("open negative code drives a switch");

	// Register writes land next cycle and touch only their own byte
	sel_write_a: assert property (@(posedge clk) disable iff (reset)
		req.wr && req.addr == 8'h16 |=> {pos_sel_r, neg_sel_r} == $past(req.wdata))
		else $error("input select write lost");
	offset_low_a: assert property (@(posedge clk) disable iff (reset)
		req.wr && req.addr == 8'h17 |=> aux_offset_word[7:0] == $past(req.wdata)
		&& $stable(offset_high_r))
		else $error("offset low byte write wrong");
	offset_word_a: assert property (@(posedge clk) disable iff (reset)
		req.wr && req.addr == 8'h18 |=> aux_offset_word[15:8] == $past(req.wdata)
		&& $stable(offset_low_r))
		else $error("offset high byte write wrong");
	fs_low_a: assert property (@(posedge clk) disable iff (reset)
		req.wr && req.addr == 8'h19 |=> aux_fullscale_word[7:0] == $past(req.wdata)
		&& $stable(fullscale_high_r))
		else $error("full-scale low byte write wrong");
	fs_high_a: assert property (@(posedge clk) disable iff (reset)
		req.wr && req.addr == 8'h1a |=> aux_fullscale_word[15:8] == $past(req.wdata)
		&& $stable(fullscale_low_r))
		else $error("full-scale high byte write wrong");

	// Register reads: data stands in the cycle after the strobe only
	read_window_a: assert property (@(posedge clk) disable iff (reset)
		!$past(req.rd) |-> rdata == 8'h00)
		else $error("read data outside its cycle");
	read_sel_a: assert property (@(posedge clk) disable iff (reset)
		req.rd && req.addr == 8'h16 |=> rdata == {$past(pos_sel_r), $past(neg_sel_r)})
		else $error("input select read wrong");
	read_offl_a: assert property (@(posedge clk) disable iff (reset)
		req.rd && req.addr == 8'h17 |=> rdata == $past(aux_offset_word[7:0]))
		else $error("offset low byte read wrong");
	read_offh_a: assert property (@(posedge clk) disable iff (reset)
		req.rd && req.addr == 8'h18 |=> rdata == $past(aux_offset_word[15:8]))
		else $error("offset high byte read wrong");
	read_fsl_a: assert property (@(posedge clk) disable iff (reset)
		req.rd && req.addr == 8'h19 |=> rdata == $past(aux_fullscale_word[7:0]))
		else $error("full-scale low byte read wrong");
	read_fsh_a: assert property (@(posedge clk) disable iff (reset)
		req.rd && req.addr == 8'h1a |=> rdata == $past(aux_fullscale_word[15:8]))
		else $error("full-scale high byte read wrong");
	read_res0_a: assert property (@(posedge clk) disable iff (reset)
		req.rd && req.addr == 8'h1b |=> rdata == $past(cal_data[7:0]))
		else $error("result low byte read wrong");
	read_res1_a: assert property (@(posedge clk) disable iff (reset)
		req.rd && req.addr == 8'h1c |=> rdata == $past(cal_data[15:8]))
		else $error("result middle byte read wrong");
	read_res2_a: assert property (@(posedge clk) disable iff (reset)
		req.rd && req.addr == 8'h1d |=> rdata == $past(cal_data[23:16]))
		else $error("result high byte read wrong");

	// Main scenarios
	cal_done_c: cover property (@(posedge clk) disable iff (reset) cal_valid);
	sat_c: cover property (@(posedge clk) disable iff (reset) raw_valid && shifted > 29'sh007fffff);
	gain_c: cover property (@(posedge clk) disable iff (reset)
		raw_valid && aux_fullscale_word != 16'h4000);
	open_c: cover property (@(posedge clk) disable iff (reset) neg_sel_r == 4'hf);
	result_read_c: cover property (@(posedge clk) disable iff (reset) req.rd && req.addr == 8'h1b);

endmodule : acal_bank

// [common/acal_params.svh]
// Register offsets, reset values and arithmetic constants of the
// auxiliary converter input select and calibration bank.
// Assumes a byte-wide register port with 8-bit addresses.
`ifndef ACAL_PARAMS_SVH
`define ACAL_PARAMS_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define ACAL_ADDR_INPUT_SELECT 8'h16
`define ACAL_ADDR_OFFSET_LOW 8'h17
`define ACAL_ADDR_OFFSET_HIGH 8'h18
`define ACAL_ADDR_FULLSCALE_LOW 8'h19
`define ACAL_ADDR_FULLSCALE_HIGH 8'h1a
`define ACAL_ADDR_RESULT_0 8'h1b
`define ACAL_ADDR_RESULT_1 8'h1c
`define ACAL_ADDR_RESULT_2 8'h1d

// ****************************************************************
// Field positions and reset values
// ****************************************************************
`define ACAL_POS_SEL_MSB 7
`define ACAL_POS_SEL_LSB 4
`define ACAL_NEG_SEL_MSB 3
`define ACAL_NEG_SEL_LSB 0
`define ACAL_RST_POS_SEL 4'h0
`define ACAL_RST_NEG_SEL 4'h1
`define ACAL_RST_OFFSET_LOW 8'h00
`define ACAL_RST_OFFSET_HIGH 8'h00
`define ACAL_RST_FULLSCALE_LOW 8'h00
`define ACAL_RST_FULLSCALE_HIGH 8'h40

// ****************************************************************
// Arithmetic
// ****************************************************************
`define ACAL_OFFSET_SHIFT 8
`define ACAL_UNITY_SHIFT 14
`define ACAL_RESULT_MAX 24'h7fffff
`define ACAL_RESULT_MIN 24'h800000

`endif

// [common/acal_pkg.sv]
// Types shared by the auxiliary converter calibration bank.
// Assumes acal_params.svh for all numeric constants.
package acal_pkg;

	// ****************************************************************
	// Input source codes, same for both legs
	// ****************************************************************
	typedef enum logic [3:0] {
		SRC_AIN0, SRC_AIN1, SRC_AIN2, SRC_AIN3, SRC_AIN4,
		SRC_AIN5, SRC_AIN6, SRC_AIN7, SRC_AIN8, SRC_AIN9,
		SRC_COMMON, SRC_TEMP_MON, SRC_AVDD_MON, SRC_DVDD_MON,
		SRC_TEST_SIGNAL, SRC_OPEN
	} acal_src_t;

	// Register port request
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} acal_req_t;

	// Analog switch controls, one-hot per leg for codes 0-14, all low for code 15
	typedef struct packed {
		logic [9:0] ain;
		logic common;
		logic temp_mon;
		logic avdd_mon;
		logic dvdd_mon;
		logic test_signal;
	} acal_route_t;

endpackage : acal_pkg

// [tb/tb_top.sv]
// Self-checking bench for the auxiliary converter input select and calibration bank.
// Assumes acal_pkg is compiled first and acal_params.svh is on the include path.
`timescale 1ns/1ps
`include "acal_params.svh"

module tb_top;
	logic clk;
	logic reset;
	acal_pkg::acal_req_t req;
	logic [7:0] rdata;
	logic raw_valid;
	logic [23:0] raw_data;
	logic cal_valid;
	logic [23:0] cal_data;
	acal_pkg::acal_route_t pos_route;
	acal_pkg::acal_route_t neg_route;
	int fail_count;
	int compares;

	acal_bank DUT
	(
		.clk(clk), .reset(reset), .req(req), .rdata(rdata),
		.raw_valid(raw_valid), .raw_data(raw_data), .cal_valid(cal_valid),
		.cal_data(cal_data), .pos_route(pos_route), .neg_route(neg_route)
	);

	// ****************************************************************
	// Clock and watchdog
	// ****************************************************************
	// Free running 40 MHz clock
	initial
	begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	// Whole run is well under a thousand cycles; a hang ends here
	initial
	begin
		repeat (5000) @(posedge clk);
		fail_count++;
		end_of_test();
	end

	// ****************************************************************
	// Compare and bus tasks
	// ****************************************************************
	task automatic end_of_test;
		$display("compares %0d mismatches %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : end_of_test

	task automatic chk_byte(input string what, input logic [7:0] e, input logic [7:0] g);
		compares++;
		if (g !== e)
		begin
			$display("CHECK FAILED %s expected %h seen %h", what, e, g);
			fail_count++;
		end
	endtask : chk_byte

	task automatic chk_route(input string what, input acal_pkg::acal_route_t e,
		input acal_pkg::acal_route_t g);
		compares++;
		if (g !== e)
		begin
			$display("CHECK FAILED %s expected %h seen %h", what, e, g);
			fail_count++;
		end
	endtask : chk_route

	task automatic chk_data(input string what, input logic [23:0] e, input logic [23:0] g);
		compares++;
		if (g !== e)
		begin
			$display("CHECK FAILED %s expected %h seen %h", what, e, g);
			fail_count++;
		end
	endtask : chk_data

	// One-cycle write strobe; released at the edge that takes it
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		req <= {a, d, 1'b1, 1'b0};
		@(posedge clk);
		req.wr <= 1'b0;
	endtask : wr_reg

	// Read data stands only in the cycle after the strobe, zero after that
	task automatic rd_check(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk);
		req <= {a, 8'h00, 1'b0, 1'b1};
		@(posedge clk);
		req.rd <= 1'b0;
		@(negedge clk);
		chk_byte("read data", e, rdata);
		@(negedge clk);
		chk_byte("idle read data", 8'h00, rdata);
	endtask : rd_check

	// ****************************************************************
	// Expected values
	// ****************************************************************
	// One-hot switch pattern for a selector code; open code drives nothing
	function automatic acal_pkg::acal_route_t exp_route(input logic [3:0] c);
		acal_pkg::acal_route_t r;
		r = '0;
		if (c < 4'ha)
			r.ain[c] = 1'b1;
		else if (c == 4'ha)
			r.common = 1'b1;
		else if (c == 4'hb)
			r.temp_mon = 1'b1;
		else if (c == 4'hc)
			r.avdd_mon = 1'b1;
		else if (c == 4'hd)
			r.dvdd_mon = 1'b1;
		else if (c == 4'he)
			r.test_signal = 1'b1;
		return r;
	endfunction : exp_route

	// Wide signed arithmetic so no intermediate wraps before clamping
	function automatic logic [23:0] cal_expect(input logic [23:0] x, input logic [15:0] o,
		input logic [15:0] f);
		longint v;
		longint xv;
		longint ov;
		longint fv;
		xv = $signed(x);
		ov = $signed(o);
		fv = f;
		v = ((xv - ov * 256) * fv) >>> 14;
		if (v > 64'sh7fffff)
			return 24'h7fffff;
		if (v < -64'sh800000)
			return 24'h800000;
		return v[23:0];
	endfunction : cal_expect

	// ****************************************************************
	// Scenarios
	// ****************************************************************
	task automatic test_reset;
		chk_route("positive route", exp_route(4'h0), pos_route);
		chk_route("negative route", exp_route(4'h1), neg_route);
		chk_data("result after reset", 24'h000000, cal_data);
		rd_check(`ACAL_ADDR_INPUT_SELECT, 8'h01);
		rd_check(`ACAL_ADDR_OFFSET_LOW, 8'h00);
		rd_check(`ACAL_ADDR_OFFSET_HIGH, 8'h00);
		rd_check(`ACAL_ADDR_FULLSCALE_LOW, 8'h00);
		rd_check(`ACAL_ADDR_FULLSCALE_HIGH, 8'h40);
		$display("test reset values done");
	endtask : test_reset

	// Every code on both legs, the other leg always holding the complement
	task automatic test_mux;
		for (int i = 0; i < 16; i++)
		begin
			wr_reg(`ACAL_ADDR_INPUT_SELECT, {i[3:0], ~i[3:0]});
			@(negedge clk);
			chk_route("positive route", exp_route(i[3:0]), pos_route);
			chk_route("negative route", exp_route(~i[3:0]), neg_route);
			rd_check(`ACAL_ADDR_INPUT_SELECT, {i[3:0], ~i[3:0]});
		end
		$display("test input select done");
	endtask : test_mux

	task automatic cal_case(input logic [15:0] o, input logic [15:0] f, input logic [23:0] x);
		wr_reg(`ACAL_ADDR_OFFSET_LOW, o[7:0]);
		wr_reg(`ACAL_ADDR_OFFSET_HIGH, o[15:8]);
		wr_reg(`ACAL_ADDR_FULLSCALE_LOW, f[7:0]);
		wr_reg(`ACAL_ADDR_FULLSCALE_HIGH, f[15:8]);
		@(posedge clk);
		raw_valid <= 1'b1;
		raw_data <= x;
		@(posedge clk);
		raw_valid <= 1'b0;
		raw_data <= ~x;
		@(negedge clk);
		chk_byte("result strobe", 8'h01, {7'h00, cal_valid});
		chk_data("calibrated result", cal_expect(x, o, f), cal_data);
		@(negedge clk);
		chk_byte("result strobe low", 8'h00, {7'h00, cal_valid});
	endtask : cal_case

	task automatic test_cal;
		cal_case(16'h0000, 16'h4000, 24'h123456);
		cal_case(16'h0100, 16'h8000, 24'h200000);
		cal_case(16'h0100, 16'h4000, 24'h200000);
		cal_case(16'h0000, 16'h8000, 24'hf00000);
		cal_case(16'hff00, 16'h4000, 24'h000010);
		cal_case(16'h0000, 16'h2000, 24'hffffff);
		cal_case(16'h0000, 16'hffff, 24'h7fffff);
		cal_case(16'h7fff, 16'h4000, 24'h800000);
		$display("test calibration done");
	endtask : test_cal

	// Result bytes read back and the low one ignores a write; calibration bytes read back
	task automatic test_result;
		cal_case(16'h0000, 16'h4000, 24'ha5c3e1);
		rd_check(`ACAL_ADDR_RESULT_0, 8'he1);
		rd_check(`ACAL_ADDR_RESULT_1, 8'hc3);
		rd_check(`ACAL_ADDR_RESULT_2, 8'ha5);
		wr_reg(`ACAL_ADDR_RESULT_0, 8'h00);
		rd_check(`ACAL_ADDR_RESULT_0, 8'he1);
		wr_reg(`ACAL_ADDR_OFFSET_LOW, 8'h3c);
		wr_reg(`ACAL_ADDR_OFFSET_HIGH, 8'h96);
		wr_reg(`ACAL_ADDR_FULLSCALE_LOW, 8'h5a);
		wr_reg(`ACAL_ADDR_FULLSCALE_HIGH, 8'h21);
		rd_check(`ACAL_ADDR_OFFSET_LOW, 8'h3c);
		rd_check(`ACAL_ADDR_OFFSET_HIGH, 8'h96);
		rd_check(`ACAL_ADDR_FULLSCALE_LOW, 8'h5a);
		rd_check(`ACAL_ADDR_FULLSCALE_HIGH, 8'h21);
		$display("test result readback done");
	endtask : test_result

	// Unmapped place keeps nothing
	task automatic test_unmapped;
		wr_reg(8'h20, 8'ha5);
		rd_check(8'h20, 8'h00);
		$display("test unmapped done");
	endtask : test_unmapped

	// ****************************************************************
	// Main sequence
	// ****************************************************************
	initial
	begin
		reset = 1'b1;
		req = '0;
		raw_valid = 1'b0;
		raw_data = 24'h000000;
		fail_count = 0;
		compares = 0;
		repeat (12) @(posedge clk);
		reset <= 1'b0;
		test_reset();
		test_mux();
		test_cal();
		test_result();
		test_unmapped();
		// Second reset after every register was changed
		@(posedge clk);
		reset <= 1'b1;
		repeat (2) @(posedge clk);
		reset <= 1'b0;
		test_reset();
		end_of_test();
	end
endmodule : tb_top
